// ---- bench/clg_ctrl_model.sv ----
// Purpose: behavioural stand-in for the four serial controllers
// Assumes: strobes active low; address strobe sampled on the rising clock, data strobe used unclocked
// Notes:   read data is latched address xor 5a; idle bus shows inverse
`timescale 1ns/1ns
`default_nettype none
module clg_ctrl_model
(
   input  wire logic       mclk_in,
   input  wire logic       as_n_in,
   input  wire logic       ds_n_in,
   input  wire logic       sel_in,
   input  wire logic [3:0] enables_in,
   input  wire logic [7:0] bus_in,
   input  wire logic [3:0] irq_cmd_in,
   input  wire logic       ack_n_in,
   output logic      [7:0] bus_out,
   output logic            int_req_n_out
);
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] last     = 8'h00;
   logic [7:0] vec_base;
   // chain: lowest pending controller answers with its base vector
   always_comb
   begin
      vec_base = 8'h00;
      for (int k = 3; k >= 0; k--)
         if (irq_cmd_in[k])
            vec_base = 8'h40 + 8'(k) * 8'h10;
   end
   // only a selected part takes the address off the shared bus
   always_ff @(posedge mclk_in)
   begin
      if (!as_n_in && enables_in != 4'h0)
         reg_addr <= {1'b0, bus_in[6:0]};
      last <= bus_out;
   end
   // drive in a data phase or acknowledge only; a moving value elsewhere exposes stale reads
   assign bus_out = !ack_n_in ? vec_base
                    : (!ds_n_in && !sel_in) ? (reg_addr ^ 8'h5a) : ~last;
   // any pending channel pulls the shared request low
   assign int_req_n_out = ~|irq_cmd_in;
endmodule // clg_ctrl_model
`default_nettype wire

// ---- bench/clg_top_properties.sv ----
// Purpose: port-level properties of the comm glue top
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every clg_top instance below the module
`timescale 1ns/1ns
`default_nettype none
module clg_top_properties
   import clg_pkg::*;
(
   input wire logic               mclk_in,
   input wire logic               reset_in,
   input wire logic [15:0]        host_io_bus_in,
   input wire logic               host_address_pulse_in,
   input wire logic [SW_BITS-1:0] switch_line_code_in,
   input wire logic               host_interrupt_ack_n_in,
   input wire logic               section_addressed_out,
   input wire logic [3:0]         latched_line_select_out,
   input wire logic [3:0]         returned_device_addr_low_out,
   input wire logic [7:0]         ack_vector_out,
   input wire logic [15:0]        local_addr_in,
   input wire logic [7:0]         local_data_bus_in,
   input wire logic               local_write_in,
   input wire logic [3:0]         controller_enables_out,
   input wire logic               periph_address_strobe_n_out,
   input wire logic               periph_data_strobe_n_out,
   input wire logic               addr_data_select_out,
   input wire logic               addr_data_select_n_out,
   input wire logic [7:0]         shared_periph_bus_out,
   input wire logic               shared_int_request_n_in,
   input wire logic [2:0]         local_irq_level_out,
   input wire logic [3:0]         modem_disable_sw_in,
   input wire logic [7:0]         dsr_status_out
);
   // everything here lives in the one clock domain
   default clocking dck @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   chk_flag_set: assert property ($rose(host_address_pulse_in) &&
      host_io_bus_in[15:10] == switch_line_code_in ##1 $stable(host_io_bus_in)
      |-> ##[0:1] section_addressed_out) else $error("addressed flag not set");
   chk_line_latch: assert property ($rose(host_address_pulse_in) ##1
      $stable(host_io_bus_in) |-> ##[0:1] latched_line_select_out == host_io_bus_in[3:0])
      else $error("line select not captured");
   chk_one_hot: assert property (controller_enables_out != 4'h0 |->
      $onehot(controller_enables_out)) else $error("controller enables not one-hot");
   chk_strobes_apart: assert property (!periph_address_strobe_n_out |->
      periph_data_strobe_n_out) else $error("both strobes low");
   chk_select_pair: assert property (addr_data_select_n_out != addr_data_select_out)
      else $error("select pair not complementary");
   chk_addr_on_bus: assert property (!periph_address_strobe_n_out |->
      addr_data_select_out && shared_periph_bus_out[6:0] == local_addr_in[7:1])
      else $error("address phase bus wrong");
   chk_data_on_bus: assert property (!periph_data_strobe_n_out && local_write_in |->
      !addr_data_select_out && shared_periph_bus_out == local_data_bus_in)
      else $error("write data phase bus wrong");
   chk_irq_level: assert property (!shared_int_request_n_in ##1
      !shared_int_request_n_in |-> local_irq_level_out == 3'h3)
      else $error("irq level not three");
   chk_ack_freeze: assert property (!host_interrupt_ack_n_in[*3] |->
      $stable(returned_device_addr_low_out)) else $error("ack code moved");
   chk_vector_form: assert property (!host_interrupt_ack_n_in[*2] |->
      ack_vector_out == {ACK_FUNC_CODE, returned_device_addr_low_out})
      else $error("ack vector malformed");
   chk_dsr_forced: assert property (modem_disable_sw_in[0] ##1
      modem_disable_sw_in[0] |-> dsr_status_out == 8'h00) else $error("dsr not forced");
endmodule // clg_top_properties

bind clg_top clg_top_properties i_clg_top_properties (.mclk_in, .reset_in,
   .host_io_bus_in, .host_address_pulse_in, .switch_line_code_in,
   .host_interrupt_ack_n_in, .section_addressed_out, .latched_line_select_out,
   .returned_device_addr_low_out, .ack_vector_out, .local_addr_in, .local_data_bus_in,
   .local_write_in, .controller_enables_out, .periph_address_strobe_n_out,
   .periph_data_strobe_n_out, .addr_data_select_out, .addr_data_select_n_out,
   .shared_periph_bus_out, .shared_int_request_n_in, .local_irq_level_out,
   .modem_disable_sw_in, .dsr_status_out);
`default_nettype wire

// ---- bench/clg_top_tb.sv ----
// Purpose: self-checking bench for the comm glue top
// Assumes: 10 MHz clock, reset held 16 cycles
// Notes:   one task per scenario; waits are bounded
`timescale 1ns/1ns
`default_nettype none
module clg_top_tb;
   import clg_pkg::*;
   logic        mclk_in, reset_in, pulse, ack_n, strobe, wr, lack, sect, attn_n, rdy;
   logic        oe, as_n, ds_n, sel, sel_n, pboe, ireq_n, iack_n;
   logic [15:0] hbus, laddr;
   logic [5:0]  sw;
   logic [3:0]  lsel, rdal, en, en_seen, msw, irq_cmd;
   logic [7:0]  ldata, ldo, vec, pbo, pbi, ring, dsr, dcd, cts, rs, ds, dc, cs, rdata;
   logic [2:0]  lvl;
   logic [1:0]  oe_seen;
   int          bad_count = 0;
   int          cmp_count = 0;

   clg_top i_clg_top (.mclk_in(mclk_in), .reset_in(reset_in), .host_io_bus_in(hbus),
      .host_address_pulse_in(pulse), .switch_line_code_in(sw),
      .host_interrupt_ack_n_in(ack_n), .section_addressed_out(sect),
      .latched_line_select_out(lsel), .comm_attention_n_out(attn_n),
      .returned_device_addr_low_out(rdal), .local_addr_in(laddr),
      .local_data_bus_in(ldata), .local_strobe_in(strobe), .local_write_in(wr),
      .local_data_bus_out(ldo), .local_data_oe_out(oe), .local_ready_out(rdy),
      .ack_vector_out(vec), .controller_enables_out(en),
      .periph_address_strobe_n_out(as_n), .periph_data_strobe_n_out(ds_n),
      .addr_data_select_out(sel), .addr_data_select_n_out(sel_n),
      .shared_periph_bus_out(pbo), .shared_periph_bus_oe_out(pboe),
      .shared_periph_bus_in(pbi), .shared_int_request_n_in(ireq_n),
      .local_int_ack_in(lack), .shared_int_acknowledge_n_out(iack_n),
      .local_irq_level_out(lvl), .ring_in(ring), .dsr_in(dsr), .dcd_in(dcd),
      .cts_in(cts), .modem_disable_sw_in(msw), .ring_status_out(rs),
      .dsr_status_out(ds), .dcd_to_ctrl_out(dc), .cts_to_ctrl_out(cs));
   clg_ctrl_model i_clg_ctrl_model (.mclk_in(mclk_in), .as_n_in(as_n), .ds_n_in(ds_n),
      .sel_in(sel), .enables_in(en), .bus_in(pbo), .irq_cmd_in(irq_cmd),
      .ack_n_in(iack_n), .bus_out(pbi), .int_req_n_out(ireq_n));

   // free-running clock
   initial
   begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   task automatic wrap_up;
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // one local cycle; strobe held until ready, then dropped for a cycle
   task automatic lbus(input logic [15:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk_in);
      laddr <= a;
      wr <= w;
      ldata <= d;
      strobe <= 1'b1;
      do
      begin
         @(negedge mclk_in);
         n++;
         if (as_n === 1'b0)
            en_seen = en;
         if (ds_n === 1'b0)
            oe_seen = {pboe, oe};
      end
      while (rdy !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         bad_count++;
         wrap_up();
      end
      rdata = ldo;
      @(posedge mclk_in);
      strobe <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic attn(input logic [3:0] i, input logic v);
      lbus({8'hc1, 1'b0, i[2:0], (i[3] ? ATN_LOW_GRP1 : ATN_LOW_GRP0)}, 1'b1, {7'h0, v});
   endtask

   task automatic hack(input logic [3:0] e);
      @(posedge mclk_in);
      ack_n <= 1'b0;
      repeat (2) @(negedge mclk_in);
      chk("ack code", {4'h0, e}, {4'h0, rdal});
      chk("ack vector", {ACK_FUNC_CODE, e}, vec);
   endtask

   task automatic unack;
      @(posedge mclk_in);
      ack_n <= 1'b1;
      @(posedge mclk_in);
   endtask

   task automatic hpulse(input logic [15:0] h);
      @(posedge mclk_in);
      hbus <= h;
      @(posedge mclk_in);
      pulse <= 1'b1;
      repeat (3) @(posedge mclk_in);
      pulse <= 1'b0;
      @(negedge mclk_in);
   endtask

   // matching then non-matching host word; flag reloads each pulse
   task automatic t_host;
      hpulse({6'h2d, 6'h00, 4'ha});
      chk("addressed", 8'h01, {7'h0, sect});
      chk("line select", 8'h0a, {4'h0, lsel});
      hpulse({6'h2c, 6'h3f, 4'h5});
      chk("not addressed", 8'h00, {7'h0, sect});
   endtask

   // each attention bit alone: code equals index, stays until cleared
   task automatic t_attn_all;
      for (int i = 0; i < 16; i++)
      begin
         attn(4'(i), 1'b1);
         repeat (3) @(negedge mclk_in);
         chk("attn set", 8'h00, {7'h0, attn_n});
         hack(4'(i));
         unack();
         attn(4'(i), 1'b0);
         repeat (3) @(negedge mclk_in);
         chk("attn clear", 8'h01, {7'h0, attn_n});
      end
   endtask

   // several pending: highest first, code frozen during ack
   task automatic t_priority;
      attn(4'd10, 1'b1);
      attn(4'd7, 1'b1);
      hack(4'd7);
      attn(4'd0, 1'b1);
      chk("frozen", 8'h07, {4'h0, rdal});
      unack();
      hack(4'd0);
      unack();
      attn(4'd0, 1'b0);
      attn(4'd7, 1'b0);
      hack(4'd10);
      unack();
      attn(4'd10, 1'b0);
   endtask

   // write then read register 3 channel A of every controller
   task automatic t_ctrl;
      logic [15:0] a;
      for (int c = 0; c < 4; c++)
      begin
         a = {8'hff, 2'(c), 1'b1, 4'h3, 1'b1};
         en_seen = 4'h0;
         lbus(a, 1'b1, 8'h96);
         chk("enables", 8'h01 << c, {4'h0, en_seen});
         chk("write drive", 8'h02, {6'h0, oe_seen});
         lbus(a, 1'b0, 8'h00);
         chk("read data", {1'b0, a[7:1]} ^ 8'h5a, rdata);
         chk("read drive", 8'h01, {6'h0, oe_seen});
      end
   endtask

   // shared request and acknowledge pass through
   task automatic t_irq;
      irq_cmd <= 4'b0100;
      repeat (3) @(negedge mclk_in);
      chk("irq level", 8'h03, {5'h0, lvl});
      @(posedge mclk_in);
      lack <= 1'b1;
      repeat (2) @(negedge mclk_in);
      chk("ack out", 8'h00, {7'h0, iack_n});
      @(negedge mclk_in);
      chk("ack vector in", 8'h60, ldo);
      chk("ack drive", 8'h01, {7'h0, oe});
      @(posedge mclk_in);
      lack <= 1'b0;
      irq_cmd <= 4'h0;
      repeat (3) @(negedge mclk_in);
      chk("irq idle", 8'h00, {5'h0, lvl});
   endtask

   // every disable switch pattern against fixed modem inputs
   task automatic t_modem;
      for (int m = 0; m < 16; m++)
      begin
         @(posedge mclk_in);
         msw <= 4'(m);
         repeat (3) @(negedge mclk_in);
         chk("dsr", m[0] ? 8'h00 : 8'h3c, ds);
         chk("dcd", m[1] ? 8'h00 : 8'hc3, dc);
         chk("cts", m[2] ? 8'h00 : 8'h5a, cs);
         chk("ring", m[3] ? 8'h00 : 8'ha5, rs);
      end
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      {pulse, strobe, wr, lack} = 4'h0;
      ack_n = 1'b1;
      reset_in = 1'b1;
      {hbus, laddr} = 32'h0;
      sw = 6'h2d;
      {ldata, ring, dsr, dcd, cts} = {8'h00, 8'ha5, 8'h3c, 8'hc3, 8'h5a};
      {msw, irq_cmd, en_seen} = 12'h0;
      repeat (16) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      t_host();
      t_attn_all();
      t_priority();
      t_ctrl();
      t_irq();
      t_modem();
      wrap_up();
   end
endmodule // clg_top_tb
`default_nettype wire

// ---- hdl/clg_attn_encoder.sv ----
// Purpose: sixteen-bit attention priority encoder
// Assumes: bit 0 is line 0 receive, bit 15 line 7 transmit
// Notes:   combinational; code is the request index, any_out flags a request
`timescale 1ns/1ns
`default_nettype none
module clg_attn_encoder
   import clg_pkg::*;
(
   input  wire logic [15:0] pending_in,
   output logic      [3:0]  code_out,
   output logic             any_out
);
   // lowest index wins, scanning from the high end downwards
   always_comb
   begin
      code_out = CODE_NONE;
      for (int i = 15; i >= 0; i--)
      begin
         if (pending_in[i])
         begin
            code_out = 4'(i);
         end
      end
      any_out = |pending_in;
   end
endmodule // clg_attn_encoder
`default_nettype wire

// ---- hdl/clg_bus_xlate.sv ----
// Purpose: microprocessor cycle to multiplexed address/data strobes
// Assumes: request held high until done pulse
// Notes:   address phase then data phase, each STROBE_CYC cycles long
`timescale 1ns/1ns
`default_nettype none
module clg_bus_xlate
   import clg_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic       req_in,
   output logic            as_n_out,
   output logic            ds_n_out,
   output logic            sel_addr_out,
   output logic            done_out
);
   clg_state_t state;
   clg_state_t next_state;
   logic [1:0] cnt;
   logic [1:0] next_cnt;

   // sequencer: gap phase lets address settle before data turnaround
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         CLG_IDLE:
         begin
            if (req_in)
            begin
               next_state = CLG_ADDR;
               next_cnt = STROBE_CNT;
            end
         end
         CLG_ADDR:
         begin
            if (cnt == 2'h0)
               next_state = CLG_GAP;
            else
               next_cnt = cnt - 2'h1;
         end
         CLG_GAP:
         begin
            next_state = CLG_DATA;
            next_cnt = STROBE_CNT;
         end
         CLG_DATA:
         begin
            if (cnt == 2'h0)
               next_state = CLG_DONE;
            else
               next_cnt = cnt - 2'h1;
         end
         CLG_DONE:
         begin
            if (!req_in)
               next_state = CLG_IDLE;
         end
         default:
            next_state = CLG_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state <= CLG_IDLE;
         cnt <= 2'h0;
         as_n_out <= 1'b1;
         ds_n_out <= 1'b1;
         sel_addr_out <= 1'b1;
         done_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         as_n_out <= !(next_state == CLG_ADDR);
         ds_n_out <= !(next_state == CLG_DATA);
         sel_addr_out <= (next_state == CLG_ADDR) || (next_state == CLG_IDLE);
         done_out <= (next_state == CLG_DONE) && (state == CLG_DATA);
      end
   end
endmodule // clg_bus_xlate
`default_nettype wire

// ---- hdl/clg_pkg.sv ----
// Purpose: shared constants for the comm line attention and bus glue
// Assumes: single 10 MHz clock, synchronous inputs
// Notes:   address fields, strobe timing and encodings live here
package clg_pkg;
   // host side
   localparam int SW_BITS        = 6;
   localparam int LINE_BITS      = 4;
   // local address decode
   localparam logic [15:0] CTRL_PAGE      = 16'hff80;
   localparam logic [3:0]  ATN_IO_OP      = 4'hc;
   localparam logic [3:0]  ATN_IO_REG     = 4'h1;
   localparam logic [3:0]  ATN_LOW_GRP0   = 4'h7;
   localparam logic [3:0]  ATN_LOW_GRP1   = 4'h9;
   localparam logic [3:0]  ACK_FUNC_CODE  = 4'h8;
   localparam logic [3:0]  CODE_NONE      = 4'h0;
   // translator timing
   localparam int CLK_NS         = 100;
   localparam int STROBE_NS      = 200;
   localparam int STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] STROBE_CNT = 2'(STROBE_CYC - 1);
   typedef enum logic [2:0] {
      CLG_IDLE,
      CLG_ADDR,
      CLG_GAP,
      CLG_DATA,
      CLG_DONE
   } clg_state_t;
endpackage

// ---- hdl/clg_top.sv ----
// Purpose: comm section glue: host line recognition, attention priority,
//          controller decode, bus translation and interrupt chaining
// Assumes: all inputs synchronous to mclk_in; controllers are outside
// Notes:   controller chain and vector nibble come from the controllers
// Contract
// - match six upper host bits with switch
// - address pulse with match sets addressed flag
// - latch four low host bits as line
// - controller registers at page ff80, fields decoded
// - one of four controller enables by bits 7:6
// - mux address bits 7:1 or data onto bus
// - address strobe low, then data strobe low
// - read phase returns controller data or vector
// - controller interrupts presented at level three
// - channel events request microprocessor interrupt
// - vector low nibble names channel and cause
// - daisy chain, controller zero highest priority
// - only highest chain member answers acknowledge
// - write sets or clears one attention bit
// - attention addresses c1, line nibble, 7 or 9
// - encoder code and common attention output
// - line 0 receive highest, one at a time
// - host acknowledge freezes code in latch
// - frozen code to host and vector low nibble
// - ring and dsr readable on input ports
// - modem inputs forceable inactive by switches
`timescale 1ns/1ns
`default_nettype none
module clg_top
   import clg_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 reset_in,
   // host io bus side
   input  wire logic [15:0]          host_io_bus_in,
   input  wire logic                 host_address_pulse_in,
   input  wire logic [SW_BITS-1:0]   switch_line_code_in,
   input  wire logic                 host_interrupt_ack_n_in,
   output logic                      section_addressed_out,
   output logic [LINE_BITS-1:0]      latched_line_select_out,
   output logic                      comm_attention_n_out,
   output logic [3:0]                returned_device_addr_low_out,
   // local microprocessor side
   input  wire logic [15:0]          local_addr_in,
   input  wire logic [7:0]           local_data_bus_in,
   input  wire logic                 local_strobe_in,
   input  wire logic                 local_write_in,
   output logic [7:0]                local_data_bus_out,
   output logic                      local_data_oe_out,
   output logic                      local_ready_out,
   output logic [7:0]                ack_vector_out,
   // controllers side
   output logic [3:0]                controller_enables_out,
   output logic                      periph_address_strobe_n_out,
   output logic                      periph_data_strobe_n_out,
   output logic                      addr_data_select_out,
   output logic                      addr_data_select_n_out,
   output logic [7:0]                shared_periph_bus_out,
   output logic                      shared_periph_bus_oe_out,
   input  wire logic [7:0]           shared_periph_bus_in,
   input  wire logic                 shared_int_request_n_in,
   input  wire logic                 local_int_ack_in,
   output logic                      shared_int_acknowledge_n_out,
   output logic [2:0]                local_irq_level_out,
   // modem status
   input  wire logic [7:0]           ring_in,
   input  wire logic [7:0]           dsr_in,
   input  wire logic [7:0]           dcd_in,
   input  wire logic [7:0]           cts_in,
   input  wire logic [3:0]           modem_disable_sw_in,
   output logic [7:0]                ring_status_out,
   output logic [7:0]                dsr_status_out,
   output logic [7:0]                dcd_to_ctrl_out,
   output logic [7:0]                cts_to_ctrl_out
);
   localparam logic [2:0] IRQ_LEVEL = 3'h3;

   logic        line_address_match;
   logic        pulse_d;
   logic        next_addressed;
   logic [3:0]  next_line;
   logic [15:0] attn;
   logic [15:0] next_attn;
   logic [3:0]  priority_code;
   logic        any_attn;
   logic [3:0]  ack_code;
   logic [3:0]  next_ack_code;
   logic        ack_d;
   logic        ack_latch_clock;
   logic        ctrl_sel;
   logic        attn_sel;
   logic [2:0]  attn_bit;
   logic        xl_req;
   logic        xl_as_n;
   logic        xl_ds_n;
   logic        xl_sel;
   logic        xl_done;
   logic        busy;
   logic        next_busy;

   // host word match against the line-address switch
   assign line_address_match =
      (host_io_bus_in[15:10] == switch_line_code_in);

   // leading edge of the address pulse, host side latch
   always_comb
   begin
      next_addressed = section_addressed_out;
      next_line = latched_line_select_out;
      if (host_address_pulse_in && !pulse_d)
      begin
         next_addressed = line_address_match;
         next_line = host_io_bus_in[3:0];
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         pulse_d <= 1'b0;
         section_addressed_out <= 1'b0;
         latched_line_select_out <= 4'h0;
      end
      else
      begin
         pulse_d <= host_address_pulse_in;
         section_addressed_out <= next_addressed;
         latched_line_select_out <= next_line;
      end
   end

   // local address decode; bit 0 must be one for controller access
   assign ctrl_sel = local_strobe_in && (local_addr_in[15:8] == CTRL_PAGE[15:8])
                     && local_addr_in[0];
   assign attn_sel = local_strobe_in && local_write_in
                     && (local_addr_in[15:12] == ATN_IO_OP)
                     && (local_addr_in[11:8] == ATN_IO_REG)
                     && !local_addr_in[7]
                     && ((local_addr_in[3:0] == ATN_LOW_GRP0)
                         || (local_addr_in[3:0] == ATN_LOW_GRP1));
   // bit index: group selects upper half, bits 6:4 the latch cell
   assign attn_bit = local_addr_in[6:4];

   // attention latches: held until microcode writes zero
   always_comb
   begin
      next_attn = attn;
      if (attn_sel && !busy)
      begin
         next_attn[{local_addr_in[3] , attn_bit}] = local_data_bus_in[0];
      end
   end

   clg_attn_encoder u_enc
   (
      .pending_in (attn),
      .code_out   (priority_code),
      .any_out    (any_attn)
   );

   // host acknowledge edge freezes the current code
   assign ack_latch_clock = !host_interrupt_ack_n_in && ack_d;
   always_comb
   begin
      next_ack_code = ack_code;
      if (ack_latch_clock)
         next_ack_code = priority_code;
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         attn <= 16'h0000;
         ack_d <= 1'b1;
         ack_code <= CODE_NONE;
         comm_attention_n_out <= 1'b1;
         returned_device_addr_low_out <= 4'h0;
         ack_vector_out <= 8'h00;
      end
      else
      begin
         attn <= next_attn;
         ack_d <= host_interrupt_ack_n_in;
         ack_code <= next_ack_code;
         comm_attention_n_out <= !any_attn;
         returned_device_addr_low_out <= next_ack_code;
         ack_vector_out <= {ACK_FUNC_CODE, next_ack_code};
      end
   end

   // translator runs one controller cycle per local strobe
   assign xl_req = ctrl_sel;
   clg_bus_xlate u_xl
   (
      .mclk_in      (mclk_in),
      .reset_in     (reset_in),
      .req_in       (xl_req),
      .as_n_out     (xl_as_n),
      .ds_n_out     (xl_ds_n),
      .sel_addr_out (xl_sel),
      .done_out     (xl_done)
   );

   // busy blocks a second attention write in one long strobe
   always_comb
   begin
      next_busy = busy;
      if (!local_strobe_in)
         next_busy = 1'b0;
      else if (attn_sel)
         next_busy = 1'b1;
   end

   // controller side registers; all outputs from flops
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         busy <= 1'b0;
         controller_enables_out <= 4'h0;
         periph_address_strobe_n_out <= 1'b1;
         periph_data_strobe_n_out <= 1'b1;
         addr_data_select_out <= 1'b1;
         addr_data_select_n_out <= 1'b0;
         shared_periph_bus_out <= 8'h00;
         shared_periph_bus_oe_out <= 1'b0;
         local_data_bus_out <= 8'h00;
         local_data_oe_out <= 1'b0;
         local_ready_out <= 1'b0;
         shared_int_acknowledge_n_out <= 1'b1;
         local_irq_level_out <= 3'h0;
      end
      else
      begin
         busy <= next_busy;
         controller_enables_out <= (ctrl_sel || local_int_ack_in)
            ? 4'(4'h1 << local_addr_in[7:6]) : 4'h0;
         periph_address_strobe_n_out <= xl_as_n;
         periph_data_strobe_n_out <= xl_ds_n;
         addr_data_select_out <= xl_sel;
         addr_data_select_n_out <= !xl_sel;
         // address bits 7:1 in phase one, data byte in write data phase
         shared_periph_bus_out <= xl_sel ? {1'b0, local_addr_in[7:1]}
                                         : local_data_bus_in;
         shared_periph_bus_oe_out <= ctrl_sel && (xl_sel || local_write_in);
         // read phase or acknowledge passes controller byte back
         if ((!xl_ds_n && !local_write_in) || local_int_ack_in)
            local_data_bus_out <= shared_periph_bus_in;
         else if (ack_latch_clock)
            local_data_bus_out <= {ACK_FUNC_CODE, priority_code};
         local_data_oe_out <= ((!xl_ds_n && !local_write_in) || local_int_ack_in);
         local_ready_out <= xl_done || (attn_sel && !busy);
         // chain priority lives in the controllers; one shared line here
         shared_int_acknowledge_n_out <= !local_int_ack_in;
         local_irq_level_out <= shared_int_request_n_in ? 3'h0 : IRQ_LEVEL;
      end
   end

   // modem status gated by disable switches, ring and dsr for polling
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ring_status_out <= 8'h00;
         dsr_status_out <= 8'h00;
         dcd_to_ctrl_out <= 8'h00;
         cts_to_ctrl_out <= 8'h00;
      end
      else
      begin
         dsr_status_out <= modem_disable_sw_in[0] ? 8'h00 : dsr_in;
         dcd_to_ctrl_out <= modem_disable_sw_in[1] ? 8'h00 : dcd_in;
         cts_to_ctrl_out <= modem_disable_sw_in[2] ? 8'h00 : cts_in;
         ring_status_out <= modem_disable_sw_in[3] ? 8'h00 : ring_in;
      end
   end
endmodule // clg_top
`default_nettype wire
